/* File: sdbt_core.sv */
// Ping-pong DMA buffer tracking, status and interrupt logic for a serial controller
//
// Contract
// R1 - Set buffer A overrun status bit 4 on overrun error passed to A.
// R2 - Overrun marked on byte FIFO hands to next loading buffer after filling.
// R3 - Buffer A overrun bit autoclears on reload of A or rx DMA reset.
// R4 - Status bits 2 and 3 show transmit buffer A or B active.
// R5 - Status bits 0 and 1 show receive buffer A or B active.
// R6 - Read-only 13-bit offset of next byte in receive buffer A, from zero.
// R7 - Read-only 13-bit offset of next byte in receive buffer B, from zero.
// R8 - Receive offset wraps to zero when its buffer fills and unloads.
// R9 - Read-only transmit offset of next byte fetched from active buffer.
// R10 - Transmit offset returns to zero when active buffer empties and unloads.
// R11 - Software start address of buffer A; storing begins there on load.
// R12 - Software end address of buffer A; buffer full after writing it.
// R13 - Frame error bits 8 and 9 set per buffer, clear on reload/reset.
// R14 - Address register bits 15..13 read 0,1,1; only low 13 bits writable.
// R15 - Buffers alternate per direction; never both active in one direction.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module sdbt_core
  import sdbt_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // Register port
  input  wire logic [SDBT_AW-1:0]   reg_addr,
  input  wire logic [SDBT_DW-1:0]   reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [SDBT_DW-1:0]   reg_rdata,
  // Receive side of hardware FIFO
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_ovr_err,
  input  wire logic                 rx_frm_err,
  output logic                      rx_ready,
  // RAM write port
  output logic                      ram_we,
  output logic      [SDBT_CW-1:0]   ram_addr,
  output logic                      ram_buf_b,
  output logic      [7:0]           ram_wdata,
  // Transmit side of hardware FIFO
  input  wire logic                 tx_take,
  output logic                      tx_ready,
  output logic      [SDBT_CW-1:0]   tx_offset,
  output logic                      tx_buf_b,
  // Interrupt
  output logic                      irq
);

  logic [SDBT_CW-1:0] start_a_reg, end_a_reg, rx_b_last_reg, tx_last_reg;
  logic [SDBT_CW-1:0] cnt_a_reg, cnt_b_reg, tx_cnt_reg, rx_a_addr;
  logic [1:0]         rx_loaded_reg, rx_loaded_next, tx_loaded_reg, tx_loaded_next;
  sdbt_buf_t          rx_sel_reg, rx_sel_next, tx_sel_reg, tx_sel_next;
  logic [1:0]         ovr_reg, frm_reg, rx_load, tx_load;
  logic [SDBT_IW-1:0] int_stat_reg, int_en_reg, int_set;
  logic [SDBT_DW-1:0] status_word, rd_mux;
  logic               ctrl_wr, dma_rst, tx_go, tx_unload;
  logic               rx_take, rx_cur_a, rx_full, rx_unload;

  // Control strobes, one cycle each
  assign ctrl_wr  = reg_wr && (reg_addr == OFF_CTRL);
  assign dma_rst  = ctrl_wr && reg_wdata[CT_RX_DMA_RST];
  assign rx_load  = ctrl_wr ? {reg_wdata[CT_LOAD_RX_B], reg_wdata[CT_LOAD_RX_A]} : 2'h0;
  assign tx_load  = ctrl_wr ? {reg_wdata[CT_LOAD_TX_B], reg_wdata[CT_LOAD_TX_A]} : 2'h0;

  // Receive path: ready is high exactly while a receive buffer is active
  assign rx_take   = rx_valid && rx_ready;
  assign rx_cur_a  = (rx_sel_reg == SDBT_BUF_A);
  assign rx_a_addr = start_a_reg + cnt_a_reg;                            // R11
  assign rx_full   = rx_cur_a ? (rx_a_addr == end_a_reg)                 // R12
                              : (cnt_b_reg == rx_b_last_reg);
  assign rx_unload = rx_take && rx_full;

  // Load beats unload in the same cycle so a quick reload is not lost
  always_comb
  begin
    rx_loaded_next = rx_loaded_reg;
    if (rx_unload)
      rx_loaded_next[rx_sel_reg] = 1'b0;
    rx_loaded_next = rx_loaded_next | rx_load;
    if (dma_rst)
      rx_loaded_next = 2'h0;
    rx_sel_next = rx_sel_reg;
    if (dma_rst)
      rx_sel_next = SDBT_BUF_A;
    else if (rx_unload || (!rx_loaded_next[rx_sel_reg] && rx_loaded_next[~rx_sel_reg]))
      rx_sel_next = sdbt_buf_t'(~rx_sel_reg);                            // R15
  end
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rx_loaded_reg <= 2'h0;
      rx_sel_reg    <= SDBT_BUF_A;
      rx_ready      <= 1'b0;
    end
    else
    begin
      rx_loaded_reg <= rx_loaded_next;
      rx_sel_reg    <= rx_sel_next;
      rx_ready      <= rx_loaded_next[rx_sel_next];                     // R15
    end
  end

  // Write offsets, cleared on load or DMA reset, wrap on unload
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cnt_a_reg <= '0;
      cnt_b_reg <= '0;
    end
    else
    begin
      if (dma_rst || rx_load[0] || (rx_take && rx_cur_a && rx_full))
        cnt_a_reg <= '0;                                                 // R8
      else if (rx_take && rx_cur_a)
        cnt_a_reg <= cnt_a_reg + 1'b1;                                   // R6
      if (dma_rst || rx_load[1] || (rx_take && !rx_cur_a && rx_full))
        cnt_b_reg <= '0;                                                 // R8
      else if (rx_take && !rx_cur_a)
        cnt_b_reg <= cnt_b_reg + 1'b1;                                   // R7
    end
  end

  // Error rides on the byte, so it lands in the buffer that takes it; set wins
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ovr_reg <= 2'h0;
      frm_reg <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (rx_take && (rx_sel_reg == sdbt_buf_t'(i)) && rx_ovr_err)
          ovr_reg[i] <= 1'b1;                                            // R1 R2
        else if (dma_rst || rx_load[i])
          ovr_reg[i] <= 1'b0;                                            // R3
        if (rx_take && (rx_sel_reg == sdbt_buf_t'(i)) && rx_frm_err)
          frm_reg[i] <= 1'b1;                                            // R13
        else if (dma_rst || rx_load[i])
          frm_reg[i] <= 1'b0;                                            // R13
      end
    end
  end

  // RAM write of each accepted byte
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ram_we    <= 1'b0;
      ram_addr  <= '0;
      ram_buf_b <= 1'b0;
      ram_wdata <= 8'h00;
    end
    else
    begin
      ram_we    <= rx_take;
      ram_addr  <= rx_cur_a ? rx_a_addr : cnt_b_reg;                     // R11
      ram_buf_b <= !rx_cur_a;
      ram_wdata <= rx_data;
    end
  end

  // Transmit path
  assign tx_go     = tx_take && tx_ready;
  assign tx_unload = tx_go && (tx_cnt_reg == tx_last_reg);
  assign tx_offset = tx_cnt_reg;
  assign tx_buf_b  = (tx_sel_reg == SDBT_BUF_B);

  always_comb
  begin
    tx_loaded_next = tx_loaded_reg;
    if (tx_unload)
      tx_loaded_next[tx_sel_reg] = 1'b0;
    tx_loaded_next = tx_loaded_next | tx_load;
    tx_sel_next    = tx_sel_reg;
    if (tx_unload || (!tx_loaded_next[tx_sel_reg] && tx_loaded_next[~tx_sel_reg]))
      tx_sel_next = sdbt_buf_t'(~tx_sel_reg);                            // R15
  end
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      tx_loaded_reg <= 2'h0;
      tx_sel_reg    <= SDBT_BUF_A;
      tx_ready      <= 1'b0;
      tx_cnt_reg    <= '0;
    end
    else
    begin
      tx_loaded_reg <= tx_loaded_next;
      tx_sel_reg    <= tx_sel_next;
      tx_ready      <= tx_loaded_next[tx_sel_next];
      if (tx_unload)
        tx_cnt_reg <= '0;                                                // R10
      else if (tx_go)
        tx_cnt_reg <= tx_cnt_reg + 1'b1;                                 // R9
    end
  end

  // Software registers; only the low 13 bits of addresses hold state
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      start_a_reg   <= '0;
      end_a_reg     <= '0;
      rx_b_last_reg <= '0;
      tx_last_reg   <= '0;
      int_en_reg    <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        OFF_RX_A_START: start_a_reg   <= reg_wdata[SDBT_CW-1:0];        // R14
        OFF_RX_A_END:   end_a_reg     <= reg_wdata[SDBT_CW-1:0];        // R14
        OFF_RX_B_LAST:  rx_b_last_reg <= reg_wdata[SDBT_CW-1:0];
        OFF_TX_LAST:    tx_last_reg   <= reg_wdata[SDBT_CW-1:0];
        OFF_INT_EN:     int_en_reg    <= reg_wdata[SDBT_IW-1:0];
        default:        ;
      endcase
    end
  end

  always_comb
  begin
    status_word              = '0;
    status_word[ST_RX_A_ACT] = rx_ready && rx_cur_a;                     // R5
    status_word[ST_RX_B_ACT] = rx_ready && !rx_cur_a;                    // R5
    status_word[ST_TX_A_ACT] = tx_ready && !tx_buf_b;                    // R4
    status_word[ST_TX_B_ACT] = tx_ready && tx_buf_b;                     // R4
    status_word[ST_OVR_A]    = ovr_reg[0];                               // R1
    status_word[ST_OVR_B]    = ovr_reg[1];
    status_word[ST_FRM_A]    = frm_reg[0];                               // R13
    status_word[ST_FRM_B]    = frm_reg[1];                               // R13
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    unique case (reg_addr)
      OFF_RX_A_START: rd_mux = {ADDR_HI_CONST, start_a_reg};             // R14
      OFF_RX_A_END:   rd_mux = {ADDR_HI_CONST, end_a_reg};               // R14
      OFF_RX_A_CNT:   rd_mux = {3'h0, cnt_a_reg};                        // R6
      OFF_RX_B_CNT:   rd_mux = {3'h0, cnt_b_reg};                        // R7
      OFF_TX_CNT:     rd_mux = {3'h0, tx_cnt_reg};                       // R9
      OFF_STATUS:     rd_mux = status_word;
      OFF_RX_B_LAST:  rd_mux = {3'h0, rx_b_last_reg};
      OFF_TX_LAST:    rd_mux = {3'h0, tx_last_reg};
      OFF_INT_STAT:   rd_mux = {10'h000, int_stat_reg};
      OFF_INT_EN:     rd_mux = {10'h000, int_en_reg};
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys)
    reg_rdata <= (nrst && reg_rd) ? rd_mux : '0;

  // Interrupts: sticky events, set beats a simultaneous clear
  always_comb
  begin
    int_set              = '0;
    int_set[IB_RX_A_ULD] = rx_unload && rx_cur_a;
    int_set[IB_RX_B_ULD] = rx_unload && !rx_cur_a;
    int_set[IB_TX_A_ULD] = tx_unload && !tx_buf_b;
    int_set[IB_TX_B_ULD] = tx_unload && tx_buf_b;
    int_set[IB_OVR]      = rx_take && rx_ovr_err;
    int_set[IB_FRM]      = rx_take && rx_frm_err;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      int_stat_reg <= '0;
      irq          <= 1'b0;
    end
    else
    begin
      if (reg_wr && (reg_addr == OFF_INT_CLR))
        int_stat_reg <= (int_stat_reg & ~reg_wdata[SDBT_IW-1:0]) | int_set;
      else
        int_stat_reg <= int_stat_reg | int_set;
      irq <= |(int_stat_reg & int_en_reg);
    end
  end

  // Checks
  a_ovr_a_set: assert property (@(posedge clk_sys) disable iff (!nrst) // R1
    rx_take && rx_cur_a && rx_ovr_err |=> ovr_reg[0])
    else $error("overrun A not flagged");
  a_ovr_from_fifo: assert property (@(posedge clk_sys) disable iff (!nrst) // R2
    $rose(ovr_reg[1]) |-> $past(rx_take && !rx_cur_a && rx_ovr_err))
    else $error("overrun B set without cause");
  a_ovr_a_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // R3
    rx_load[0] && !(rx_take && rx_cur_a && rx_ovr_err) |=> !ovr_reg[0])
    else $error("overrun A not cleared by load");
  a_tx_one_act: assert property (@(posedge clk_sys) disable iff (!nrst) // R4
    tx_load[0] && !tx_buf_b && !tx_unload
      |=> status_word[ST_TX_A_ACT] && !status_word[ST_TX_B_ACT])
    else $error("transmit A not the only active buffer");
  a_rx_act_load: assert property (@(posedge clk_sys) disable iff (!nrst) // R5
    rx_load[0] && !rx_loaded_reg[1] && !dma_rst |=> status_word[ST_RX_A_ACT])
    else $error("receive A not active after load");
  a_cnt_a_step: assert property (@(posedge clk_sys) disable iff (!nrst) // R6
    rx_take && rx_cur_a && !rx_full && !rx_load[0] && !dma_rst
      |=> cnt_a_reg == $past(cnt_a_reg) + 13'h0001)
    else $error("offset A did not step");
  a_cnt_b_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // R7
    !(rx_take && !rx_cur_a) && !rx_load[1] && !dma_rst |=> $stable(cnt_b_reg))
    else $error("offset B moved without a byte");
  a_rx_wrap: assert property (@(posedge clk_sys) disable iff (!nrst) // R8
    rx_unload |=> ($past(rx_cur_a) ? cnt_a_reg : cnt_b_reg) == 13'h0000)
    else $error("receive offset did not wrap");
  a_tx_wrap: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
    tx_unload |=> tx_cnt_reg == 13'h0000)
    else $error("transmit offset did not return to zero");
  a_ram_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
    rx_take && rx_cur_a |=> ram_we && !ram_buf_b && ram_addr == $past(rx_a_addr))
    else $error("wrong RAM address for buffer A");
  a_addr_hi: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
    reg_rd && reg_addr == OFF_RX_A_END |=> reg_rdata[15:13] == ADDR_HI_CONST)
    else $error("fixed address bits wrong");
  c_rx_unload: cover property (@(posedge clk_sys) disable iff (!nrst) rx_unload);
  c_tx_unload: cover property (@(posedge clk_sys) disable iff (!nrst) tx_unload);
  c_overrun:   cover property (@(posedge clk_sys) disable iff (!nrst) $rose(ovr_reg[0]));
  c_irq:       cover property (@(posedge clk_sys) disable iff (!nrst) $rose(irq));

endmodule

/* File: sdbt_pkg.sv */
// Constants and types for the serial DMA buffer tracking block
package sdbt_pkg;
  localparam int           SDBT_AW          = 16;
  localparam int           SDBT_DW          = 16;
  localparam int           SDBT_CW          = 13;
  localparam int           SDBT_IW          = 6;
  // Register offsets
  localparam logic [15:0]  OFF_RX_A_START   = 16'h4480;
  localparam logic [15:0]  OFF_RX_A_END     = 16'h4482;
  localparam logic [15:0]  OFF_RX_A_CNT     = 16'h4490;
  localparam logic [15:0]  OFF_RX_B_CNT     = 16'h4492;
  localparam logic [15:0]  OFF_TX_CNT       = 16'h4494;
  localparam logic [15:0]  OFF_STATUS       = 16'h44A0;
  localparam logic [15:0]  OFF_CTRL         = 16'h44A2;
  localparam logic [15:0]  OFF_RX_B_LAST    = 16'h44A4;
  localparam logic [15:0]  OFF_TX_LAST      = 16'h44A6;
  localparam logic [15:0]  OFF_INT_STAT     = 16'h44A8;
  localparam logic [15:0]  OFF_INT_CLR      = 16'h44AA;
  localparam logic [15:0]  OFF_INT_EN       = 16'h44AC;
  // Fixed upper bits of buffer address registers
  localparam logic [2:0]   ADDR_HI_CONST    = 3'h3;
  // Status bit positions
  localparam int           ST_RX_A_ACT      = 0;
  localparam int           ST_RX_B_ACT      = 1;
  localparam int           ST_TX_A_ACT      = 2;
  localparam int           ST_TX_B_ACT      = 3;
  localparam int           ST_OVR_A         = 4;
  localparam int           ST_OVR_B         = 5;
  localparam int           ST_FRM_A         = 8;
  localparam int           ST_FRM_B         = 9;
  // Control bit positions
  localparam int           CT_LOAD_RX_A     = 0;
  localparam int           CT_LOAD_RX_B     = 1;
  localparam int           CT_LOAD_TX_A     = 2;
  localparam int           CT_LOAD_TX_B     = 3;
  localparam int           CT_RX_DMA_RST    = 4;
  // Interrupt bit positions
  localparam int           IB_RX_A_ULD      = 0;
  localparam int           IB_RX_B_ULD      = 1;
  localparam int           IB_TX_A_ULD      = 2;
  localparam int           IB_TX_B_ULD      = 3;
  localparam int           IB_OVR           = 4;
  localparam int           IB_FRM           = 5;
  // Buffer select values
  typedef enum logic {SDBT_BUF_A, SDBT_BUF_B} sdbt_buf_t;
endpackage

/* File: sdbt_fifo_model.sv */
// Hardware FIFO and RAM model facing the DMA tracking core
`timescale 1ns/1ps
module sdbt_fifo_model
#(
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Receive stream
  input  wire logic        rx_ready,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_ovr_err,
  output logic             rx_frm_err,
  // Transmit stream
  input  wire logic        tx_ready,
  output logic             tx_take,
  // RAM write port
  input  wire logic        ram_we,
  input  wire logic [12:0] ram_addr,
  input  wire logic        ram_buf_b,
  input  wire logic [7:0]  ram_wdata
);
  logic [9:0]  q[$];
  logic [21:0] ram_log[$];
  int          tx_left;

  initial
  begin
    rx_valid   = 1'b0;
    rx_data    = 8'h00;
    rx_ovr_err = 1'b0;
    rx_frm_err = 1'b0;
    tx_take    = 1'b0;
    tx_left    = 0;
  end

  task automatic push(input logic [7:0] d, input logic frm);
    #1;
    // Full FIFO drops the byte; the error rides on the newest one
    if (q.size() == DEPTH)
      q[DEPTH-1][9] = 1'b1;
    else
      q.push_back({1'b0, frm, d});
  endtask

  task automatic send(input int n);
    #1;
    tx_left = n;
  endtask

  always @(posedge clk_sys)
  begin
    if (ram_we)
      ram_log.push_back({ram_buf_b, ram_addr, ram_wdata});
    if (tx_take && tx_ready)
      tx_left = tx_left - 1;
    tx_take <= nrst && (tx_left > 0);
    // Head is held until the core takes it
    if (rx_valid && rx_ready)
      void'(q.pop_front());
    if (nrst && q.size() != 0)
    begin
      rx_valid <= 1'b1;
      {rx_ovr_err, rx_frm_err, rx_data} <= q[0];
    end
    else
    begin
      rx_valid   <= 1'b0;
      rx_data    <= ~rx_data;
      rx_ovr_err <= ~rx_ovr_err;
      rx_frm_err <= ~rx_frm_err;
    end
  end
endmodule

/* File: sdbt_core_tb_top.sv */
// Self-checking testbench for the DMA buffer tracking core
`timescale 1ns/1ps
module sdbt_core_tb_top
  import sdbt_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        rx_valid, rx_ovr_err, rx_frm_err, rx_ready;
  logic [7:0]  rx_data, ram_wdata;
  logic        ram_we, ram_buf_b, tx_take, tx_ready, tx_buf_b, irq;
  logic [12:0] ram_addr, tx_offset;
  int          n_fail = 0;
  int          checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  sdbt_core i_sdbt_core (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ovr_err(rx_ovr_err),
    .rx_frm_err(rx_frm_err), .rx_ready(rx_ready), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_buf_b(ram_buf_b), .ram_wdata(ram_wdata), .tx_take(tx_take),
    .tx_ready(tx_ready), .tx_offset(tx_offset), .tx_buf_b(tx_buf_b), .irq(irq));

  sdbt_fifo_model i_sdbt_fifo_model (.clk_sys(clk_sys), .nrst(nrst), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ovr_err(rx_ovr_err),
    .rx_frm_err(rx_frm_err), .tx_ready(tx_ready), .tx_take(tx_take), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_buf_b(ram_buf_b), .ram_wdata(ram_wdata));

  task automatic print_verdict();
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk({6'h00, reg_rdata}, {6'h00, exp});
  endtask

  // Bounded waits, then a few cycles for registered status to settle
  task automatic wait_log(input int n);
    for (int i = 0; i < 200 && i_sdbt_fifo_model.ram_log.size() < n; i++)
      @(posedge clk_sys);
    if (i_sdbt_fifo_model.ram_log.size() < n)
      n_fail++;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic wait_tx();
    for (int i = 0; i < 200 && i_sdbt_fifo_model.tx_left > 0; i++)
      @(posedge clk_sys);
    if (i_sdbt_fifo_model.tx_left > 0)
      n_fail++;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_regs();
    rd_chk(OFF_RX_A_CNT, 16'h0000);
    rd_chk(OFF_RX_B_CNT, 16'h0000);
    rd_chk(OFF_TX_CNT, 16'h0000);
    rd_chk(OFF_STATUS, 16'h0000);
    wr(OFF_RX_A_START, 16'hFFFF);
    rd_chk(OFF_RX_A_START, 16'h7FFF);
    wr(OFF_RX_A_END, 16'h8000);
    rd_chk(OFF_RX_A_END, 16'h6000);
    wr(OFF_RX_A_CNT, 16'h0055);
    rd_chk(OFF_RX_A_CNT, 16'h0000);
    rd_chk(16'h4400, 16'h0000);
  endtask

  task automatic t_rx_pingpong();
    wr(OFF_RX_A_START, 16'h0010);
    wr(OFF_RX_A_END, 16'h0012);
    wr(OFF_RX_B_LAST, 16'h0001);
    wr(OFF_INT_EN, 16'h0003);
    wr(OFF_CTRL, 16'h0001);
    rd_chk(OFF_STATUS, 16'h0001);
    for (int i = 0; i < 4; i++)
      i_sdbt_fifo_model.push(8'hA0 + 8'(i), 1'b0);
    wait_log(3);
    for (int i = 0; i < 3; i++)
      chk(i_sdbt_fifo_model.ram_log[i], {1'b0, 13'h0010 + 13'(i), 8'hA0 + 8'(i)});
    rd_chk(OFF_RX_A_CNT, 16'h0000);
    rd_chk(OFF_STATUS, 16'h0000);
    rd_chk(OFF_INT_STAT, 16'h0001);
    chk({21'h0, irq}, 22'h1);
    wr(OFF_CTRL, 16'h0002);
    wait_log(4);
    chk(i_sdbt_fifo_model.ram_log[3], {1'b1, 13'h0000, 8'hA3});
    rd_chk(OFF_STATUS, 16'h0002);
    rd_chk(OFF_RX_B_CNT, 16'h0001);
    i_sdbt_fifo_model.push(8'hA4, 1'b0);
    wait_log(5);
    rd_chk(OFF_RX_B_CNT, 16'h0000);
    rd_chk(OFF_INT_STAT, 16'h0003);
    wr(OFF_INT_CLR, 16'h0003);
    rd_chk(OFF_INT_STAT, 16'h0000);
    chk({21'h0, irq}, 22'h0);
  endtask

  task automatic t_errors();
    i_sdbt_fifo_model.ram_log.delete();
    wr(OFF_CTRL, 16'h0010);
    wr(OFF_RX_A_START, 16'h0000);
    wr(OFF_RX_A_END, 16'h1FFF);
    // Nothing loaded: five bytes into a four-deep FIFO overrun it
    i_sdbt_fifo_model.push(8'h51, 1'b1);
    for (int i = 0; i < 4; i++)
      i_sdbt_fifo_model.push(8'h60 + 8'(i), 1'b0);
    wr(OFF_CTRL, 16'h0001);
    wait_log(4);
    rd_chk(OFF_STATUS, 16'h0111);
    rd_chk(OFF_RX_A_CNT, 16'h0004);
    wr(OFF_CTRL, 16'h0001);
    rd_chk(OFF_STATUS, 16'h0001);
    rd_chk(OFF_RX_A_CNT, 16'h0000);
    i_sdbt_fifo_model.push(8'h70, 1'b1);
    wait_log(5);
    rd_chk(OFF_STATUS, 16'h0101);
    wr(OFF_CTRL, 16'h0010);
    rd_chk(OFF_STATUS, 16'h0000);
    wr(OFF_INT_CLR, 16'h003F);
  endtask

  task automatic t_tx();
    wr(OFF_TX_LAST, 16'h0002);
    wr(OFF_INT_EN, 16'h0004);
    wr(OFF_CTRL, 16'h000C);
    rd_chk(OFF_STATUS, 16'h0004);
    chk({21'h0, tx_buf_b}, 22'h0);
    i_sdbt_fifo_model.send(2);
    wait_tx();
    rd_chk(OFF_TX_CNT, 16'h0002);
    i_sdbt_fifo_model.send(1);
    wait_tx();
    rd_chk(OFF_TX_CNT, 16'h0000);
    rd_chk(OFF_STATUS, 16'h0008);
    chk({21'h0, irq}, 22'h1);
    wr(OFF_INT_EN, 16'h0000);
    rd_chk(OFF_INT_STAT, 16'h0004);
    chk({21'h0, irq}, 22'h0);
    wr(OFF_INT_CLR, 16'h0004);
    rd_chk(OFF_INT_STAT, 16'h0000);
    i_sdbt_fifo_model.send(1);
    wait_tx();
    chk({tx_buf_b, 8'h00, tx_offset}, {1'b1, 8'h00, 13'h0001});
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_rx_pingpong();
    t_errors();
    t_tx();
    print_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #(25 * 20000);
    n_fail++;
    print_verdict();
  end
endmodule
